// ===== testbench/core_model.sv
/* Core sequencer model: running pc and an 8-deep return stack.
   Assumes one-cycle take pulses and a return command from the bench. */
`timescale 1ns/1ps
module core_model (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic irq_take_i,
  input wire logic [11:0] push_pc_i,
  input wire logic [11:0] vector_addr_i,
  input wire logic ret_cmd_i,
  output logic [11:0] next_pc_o,
  output logic stack_full_o,
  output logic ret_pulse_o,
  output logic core_ready_o,
  output logic [3:0] depth_o
);
  logic [11:0] pc_reg;
  logic [11:0] stack_reg [8];
  assign next_pc_o = pc_reg + 12'h001;
  assign stack_full_o = depth_o == 4'd8;
  assign core_ready_o = 1'b1;
  always_ff @(posedge clk_sys_i) begin
    ret_pulse_o <= 1'b0;
    if (!rst_n_i) begin
      pc_reg <= 12'h100;
      depth_o <= 4'd0;
    end else if (irq_take_i) begin
      stack_reg[depth_o[2:0]] <= push_pc_i;
      depth_o <= depth_o + 4'd1;
      pc_reg <= vector_addr_i;
    end else if (ret_cmd_i && depth_o != 4'd0) begin
      pc_reg <= stack_reg[depth_o[2:0] - 3'd1];
      depth_o <= depth_o - 4'd1;
      ret_pulse_o <= 1'b1;
    end else begin
      pc_reg <= pc_reg + 12'h001;
    end
  end
endmodule

// ===== testbench/tb_vectored_interrupt_controller.sv
/* Self-checking bench for the interrupt controller.
   Assumes the core model on the far side and the register map constants. */
`timescale 1ns/1ps
`include "vic_consts.svh"
module tb_vectored_interrupt_controller;
  localparam logic [5:0] PRI = `OFS_PRIMARY;
  localparam logic [5:0] ADC = `OFS_ADC_MF;
  localparam logic [5:0] EX1 = `OFS_EXT1_TB;
  localparam logic [5:0] NVM = `OFS_NVM_LV;
  localparam logic [5:0] EDG = `OFS_EDGE_SEL;
  localparam logic [5:0] OFS [7] = '{PRI, ADC, EX1, `OFS_TMR0, `OFS_TMR1, NVM, EDG};
  localparam logic [7:0] MSK [7] = '{8'h7e, 8'hff, 8'h77, 8'h33, 8'h33, 8'h33, 8'h0f};
  logic clk_sys_i, rst_n_i, rd_en, wr_en, wait_req, pin_a, pin_b, pu_a, pu_b;
  logic pu_a_o, pu_b_o, ret_cmd, stack_full, ret_pulse, core_ready, take, wake, got;
  logic [5:0] adr;
  logic [31:0] wdata, rdata, rv;
  logic [10:0] evt;
  logic [11:0] next_pc, vec, push_pc, vec_seen;
  logic [3:0] depth;
  int n_fail, checked;
  vectored_interrupt_controller dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .avs_address_i(adr), .avs_read_i(rd_en), .avs_write_i(wr_en),
    .avs_writedata_i(wdata), .avs_byteenable_i(4'h1), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wait_req), .ext_irq_pin_a_i(pin_a), .ext_irq_pin_b_i(pin_b),
    .pin_a_pullup_i(pu_a), .pin_b_pullup_i(pu_b), .overvolt_evt_i(evt[0]),
    .overcurrent_evt_i(evt[1]), .adc_done_evt_i(evt[2]), .tick_a_evt_i(evt[3]),
    .tick_b_evt_i(evt[4]), .tmr0_cmpa_evt_i(evt[5]), .tmr0_cmpp_evt_i(evt[6]),
    .tmr1_cmpa_evt_i(evt[7]), .tmr1_cmpp_evt_i(evt[8]), .nvm_write_done_evt_i(evt[9]),
    .low_voltage_evt_i(evt[10]), .next_pc_i(next_pc), .stack_full_i(stack_full),
    .return_from_irq_instr_i(ret_pulse), .core_ready_i(core_ready), .irq_take_o(take),
    .vector_addr_o(vec), .push_pc_o(push_pc), .wake_o(wake), .pin_a_pullup_o(pu_a_o),
    .pin_b_pullup_o(pu_b_o));
  core_model u_core (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .irq_take_i(take),
    .push_pc_i(push_pc), .vector_addr_i(vec), .ret_cmd_i(ret_cmd), .next_pc_o(next_pc),
    .stack_full_o(stack_full), .ret_pulse_o(ret_pulse), .core_ready_o(core_ready),
    .depth_o(depth));
  // ----------------
  // Helpers
  // ----------------
  initial begin
    clk_sys_i = 0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task bus(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    adr <= a;
    wdata <= {24'h0, d};
    wr_en <= w;
    rd_en <= !w;
    // The wait ends when waitrequest goes low; only the watchdog ends it otherwise
    do begin
      @(posedge clk_sys_i);
    end while (wait_req !== 1'b0);
    rv = rdata;
    wr_en <= 0;
    rd_en <= 0;
  endtask
  task wr(input logic [5:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task rdc(input logic [5:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(rv, {24'h0, e});
  endtask
  task clr;
    for (int i = 0; i < 7; i++) wr(OFS[i], 8'h00);
  endtask
  task ev(input logic [10:0] m);
    @(posedge clk_sys_i) evt <= m;
    @(posedge clk_sys_i) evt <= 11'h0;
  endtask
  task ret;
    @(posedge clk_sys_i) ret_cmd <= 1;
    @(posedge clk_sys_i) ret_cmd <= 0;
  endtask
  task pin(input logic a, input logic v);
    @(posedge clk_sys_i);
    if (a) pin_a <= v;
    else pin_b <= v;
    repeat (8) @(posedge clk_sys_i);
  endtask
  task waitfor(input logic w, input int lim);
    got = 0;
    for (int n = 0; n < lim && !got; n++) begin
      @(posedge clk_sys_i);
      got = ((w ? wake : take) === 1'b1);
      vec_seen = vec;
    end
  endtask
  task take_exp(input int idx);
    waitfor(1'b0, 12);
    chk(got, 1);
    chk(vec_seen, `VEC_BASE + `VEC_STEP * 12'(idx));
  endtask
  task none(input logic w);
    waitfor(w, 10);
    chk(got, 0);
  endtask
  task stop_test;
    if (n_fail == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ----------------
  // Scenarios
  // ----------------
  task t_regs;
    for (int i = 0; i < 7; i++) rdc(OFS[i], 8'h00);
    for (int i = 0; i < 7; i++) wr(OFS[i], i == 0 ? 8'h7e : 8'hff);
    for (int i = 0; i < 7; i++) rdc(OFS[i], MSK[i]);
    clr;
    wr(6'h3c, 8'hff);
    rdc(6'h3c, 8'h00);
  endtask
  task t_flags;
    wr(PRI, 8'h01);
    ev(11'h7ff);
    none(1'b0);
    rdc(PRI, 8'h31);
    for (int i = 1; i < 6; i++) rdc(OFS[i], i == 1 ? 8'h80 : 8'h30);
    wr(PRI, 8'h00);
    wr(ADC, 8'h88);
    none(1'b0);
    clr;
  endtask
  task t_prio;
    wr(ADC, 8'h08);
    wr(PRI, 8'h02);
    ev(11'h005);
    wr(PRI, 8'h13);
    take_exp(0);
    rdc(PRI, 8'h02);
    rdc(ADC, 8'h88);
    wr(PRI, 8'h03);
    take_exp(3);
    rdc(ADC, 8'h08);
    ret();
    ret();
    wr(NVM, 8'h02);
    wr(ADC, 8'h04);
    wr(PRI, 8'h01);
    ev(11'h200);
    take_exp(6);
    rdc(ADC, 8'h04);
    rdc(NVM, 8'h22);
    ret();
    clr;
    chk(depth, 0);
  endtask
  task t_pins;
    for (int c = 0; c < 4; c++) begin
      wr(EDG, 8'(c));
      wr(PRI, 8'h08);
      pin(1'b1, 1'b1);
      rdc(PRI, {1'b0, 1'(c), 6'h08});
      wr(PRI, 8'h08);
      pin(1'b1, 1'b0);
      rdc(PRI, {1'b0, 1'(c >> 1), 6'h08});
    end
    wr(PRI, 8'h00);
    pin(1'b1, 1'b1);
    rdc(PRI, 8'h00);
    wr(PRI, 8'h08);
    pin(1'b1, 1'b0);
    wr(PRI, 8'h49);
    take_exp(2);
    rdc(PRI, 8'h08);
    ret();
    wr(EDG, 8'h04);
    wr(EX1, 8'h04);
    pin(1'b0, 1'b1);
    rdc(EX1, 8'h44);
    clr;
  endtask
  task t_stack;
    wr(EX1, 8'h01);
    for (int i = 0; i < 8; i++) begin
      wr(PRI, 8'h01);
      ev(11'h008);
      take_exp(7);
    end
    wr(PRI, 8'h01);
    ev(11'h008);
    none(1'b0);
    rdc(6'h1c, 8'h17);
    rdc(6'h20, 8'h07);
    ret();
    take_exp(7);
    repeat (8) ret();
    clr;
  endtask
  task t_wake;
    ev(11'h010);
    waitfor(1'b1, 4);
    chk(got, 1);
    ev(11'h010);
    none(1'b1);
    clr;
  endtask
  task t_pull;
    @(posedge clk_sys_i) pu_a <= 1;
    repeat (3) @(posedge clk_sys_i);
    chk({pu_a_o, pu_b_o}, 2'b10);
    @(posedge clk_sys_i) {pu_a, pu_b} <= 2'b01;
    repeat (3) @(posedge clk_sys_i);
    chk({pu_a_o, pu_b_o}, 2'b01);
  endtask
  initial begin
    repeat (30000) @(posedge clk_sys_i);
    n_fail++;
    stop_test;
  end
  initial begin
    {rst_n_i, rd_en, wr_en, pin_a, pin_b, pu_a, pu_b, ret_cmd} = 8'h00;
    {adr, wdata, evt} = '0;
    n_fail = 0;
    checked = 0;
    repeat (10) @(posedge clk_sys_i);
    rst_n_i <= 1;
    t_regs;
    t_flags;
    t_prio;
    t_pins;
    t_stack;
    t_wake;
    t_pull;
    stop_test;
  end
endmodule

// ===== testbench/vic_props.sv
/* Port checker for the interrupt controller.
   Assumes it is bound into vectored_interrupt_controller. */
`timescale 1ns/1ps
// ----------------
// Assertions
// ----------------
module vic_props (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic [11:0] next_pc_i,
  input wire logic stack_full_i,
  input wire logic core_ready_i,
  input wire logic irq_take_o,
  input wire logic [11:0] vector_addr_o,
  input wire logic [11:0] push_pc_o,
  input wire logic pin_a_pullup_i,
  input wire logic pin_a_pullup_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  AST_TAKE_SPACING: assert property (irq_take_o |=> !irq_take_o [*2])
    else $error("take pulses too close");
  AST_FULL_BLOCKS: assert property (irq_take_o |-> !$past(stack_full_i))
    else $error("take while stack full");
  AST_READY: assert property (irq_take_o |-> $past(core_ready_i))
    else $error("take while core busy");
  AST_VEC_MAP: assert property (irq_take_o |->
    (vector_addr_o inside {[12'h004:12'h028]}) && vector_addr_o[1:0] == 2'b00)
    else $error("vector outside table");
  AST_VEC_HOLD: assert property (!irq_take_o |->
    $stable(vector_addr_o) && $stable(push_pc_o))
    else $error("vector changed without take");
  AST_PUSH_NEXT: assert property (irq_take_o |-> push_pc_o == $past(next_pc_i))
    else $error("pushed pc wrong");
  AST_WAIT_ONE: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low too long");
  AST_WAIT_ANS: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o)
    else $error("no bus answer");
  AST_RD_UPPER: assert property (!avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h0)
    else $error("upper read bits set");
  AST_PULLUP: assert property ($past(rst_n_i) |->
    pin_a_pullup_o == $past(pin_a_pullup_i))
    else $error("pull-up select lost");
endmodule

bind vectored_interrupt_controller vic_props u_props (.clk_sys_i(clk_sys_i),
  .rst_n_i(rst_n_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .next_pc_i(next_pc_i), .stack_full_i(stack_full_i), .core_ready_i(core_ready_i),
  .irq_take_o(irq_take_o), .vector_addr_o(vector_addr_o), .push_pc_o(push_pc_o),
  .pin_a_pullup_i(pin_a_pullup_i), .pin_a_pullup_o(pin_a_pullup_o));

// ===== verilog/vectored_interrupt_controller.sv
/*
  Vectored interrupt controller: request flags, enables, fixed priority,
  vector load with pc push, wake-up. Assumes the core sequencer takes
  the vector/push pulse, reports return and stack full, and that source
  peripherals give one-cycle event pulses on the system clock.
*/
// Implementation choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "vic_consts.svh"

module vectored_interrupt_controller
  import vic_pkg::*;
#(
  parameter logic [39:0] PRIO_ORDER = {4'd9, 4'd8, 4'd7, 4'd6, 4'd5,
                                       4'd4, 4'd3, 4'd2, 4'd1, 4'd0}
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic ext_irq_pin_a_i,
  input wire logic ext_irq_pin_b_i,
  input wire logic pin_a_pullup_i,
  input wire logic pin_b_pullup_i,
  input wire logic overvolt_evt_i,
  input wire logic overcurrent_evt_i,
  input wire logic adc_done_evt_i,
  input wire logic tick_a_evt_i,
  input wire logic tick_b_evt_i,
  input wire logic tmr0_cmpa_evt_i,
  input wire logic tmr0_cmpp_evt_i,
  input wire logic tmr1_cmpa_evt_i,
  input wire logic tmr1_cmpp_evt_i,
  input wire logic nvm_write_done_evt_i,
  input wire logic low_voltage_evt_i,
  input wire logic [11:0] next_pc_i,
  input wire logic stack_full_i,
  input wire logic return_from_irq_instr_i,
  input wire logic core_ready_i,
  output logic irq_take_o,
  output logic [11:0] vector_addr_o,
  output logic [11:0] push_pc_o,
  output logic wake_o,
  output logic pin_a_pullup_o,
  output logic pin_b_pullup_o
);

  // ---------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------
  logic [7:0] primary_int_ctrl_reg;
  logic [7:0] adc_multifunc_int_ctrl_reg;
  logic [7:0] ext1_timebase_int_ctrl_reg;
  logic [7:0] timer0_match_int_ctrl_reg;
  logic [7:0] timer1_match_int_ctrl_reg;
  logic [7:0] eeprom_lowvolt_int_ctrl_reg;
  logic [7:0] edge_select_reg;
  logic [7:0] wr_byte;
  logic wr_hit;
  logic in_service_reg;
  svc_state_t state_reg;

  assign wr_byte = avs_writedata_i[7:0];
  assign wr_hit = avs_write_i && avs_byteenable_i[0] && !avs_waitrequest_o;

  // ---------------------------------------------------------------
  // Pin synchronisers and edge detect
  // ---------------------------------------------------------------
  logic [2:0] pa_sync_reg;
  logic [2:0] pb_sync_reg;
  logic pa_level_reg;
  logic pb_level_reg;
  logic pa_edge;
  logic pb_edge;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      pa_sync_reg <= 3'h0;
      pb_sync_reg <= 3'h0;
      pa_level_reg <= 1'b0;
      pb_level_reg <= 1'b0;
    end else begin
      pa_sync_reg <= {pa_sync_reg[1:0], ext_irq_pin_a_i};
      pb_sync_reg <= {pb_sync_reg[1:0], ext_irq_pin_b_i};
      if (pa_sync_reg[1] == pa_sync_reg[2]) begin
        pa_level_reg <= pa_sync_reg[2];
      end
      if (pb_sync_reg[1] == pb_sync_reg[2]) begin
        pb_level_reg <= pb_sync_reg[2];
      end
    end
  end

  function automatic logic edge_hit(input logic [1:0] sel, input logic old_lv,
                                    input logic new_lv, input logic en);
    logic rise;
    logic fall;
    rise = !old_lv && new_lv;
    fall = old_lv && !new_lv;
    edge_hit = 1'b0;
    if (en) begin
      unique case (sel)
        `EDGE_OFF: edge_hit = 1'b0;
        `EDGE_RISE: edge_hit = rise;
        `EDGE_FALL: edge_hit = fall;
        `EDGE_BOTH: edge_hit = rise | fall;
      endcase
    end
  endfunction

  // New level qualifies only when the two late stages agree
  assign pa_edge = (pa_sync_reg[1] == pa_sync_reg[2])
                   && edge_hit(edge_select_reg[1:0], pa_level_reg, pa_sync_reg[2],
                               primary_int_ctrl_reg[`BIT_EXTA_E]);
  assign pb_edge = (pb_sync_reg[1] == pb_sync_reg[2])
                   && edge_hit(edge_select_reg[3:2], pb_level_reg, pb_sync_reg[2],
                               ext1_timebase_int_ctrl_reg[`BIT_EXTB_E]);

  // ---------------------------------------------------------------
  // Source request/enable vectors and priority pick
  // ---------------------------------------------------------------
  // Index: 0 ovp,1 ocp,2 pin a,3 adc,4 mf0,5 mf1,6 mf2,7 tick a,8 tick b,9 pin b
  logic [`NUM_SRC-1:0] src_flag;
  logic [`NUM_SRC-1:0] src_en;
  logic [`NUM_SRC-1:0] src_req;
  logic [`NUM_SRC-1:0] clr_vec;
  logic [3:0] win_idx;
  logic win_any;
  logic [2:0] mf_evt;

  assign src_flag = {ext1_timebase_int_ctrl_reg[`BIT_EXTB_F],
                     ext1_timebase_int_ctrl_reg[`BIT_TB_F0+1],
                     ext1_timebase_int_ctrl_reg[`BIT_TB_F0],
                     adc_multifunc_int_ctrl_reg[`BIT_MF_F0+2 -: 3],
                     adc_multifunc_int_ctrl_reg[`BIT_ADC_F],
                     primary_int_ctrl_reg[`BIT_EXTA_F],
                     primary_int_ctrl_reg[`BIT_OCP_F],
                     primary_int_ctrl_reg[`BIT_OVP_F]};
  assign src_en = {ext1_timebase_int_ctrl_reg[`BIT_EXTB_E],
                   ext1_timebase_int_ctrl_reg[`BIT_TB_E0+1],
                   ext1_timebase_int_ctrl_reg[`BIT_TB_E0],
                   adc_multifunc_int_ctrl_reg[`BIT_MF_E0+2 -: 3],
                   adc_multifunc_int_ctrl_reg[`BIT_ADC_E],
                   primary_int_ctrl_reg[`BIT_EXTA_E],
                   primary_int_ctrl_reg[`BIT_OCP_E],
                   primary_int_ctrl_reg[`BIT_OVP_E]};
  assign src_req = src_flag & src_en;

  always_comb begin
    win_idx = 4'h0;
    win_any = 1'b0;
    for (int k = `NUM_SRC - 1; k >= 0; k--) begin
      if (src_req[PRIO_ORDER[k*4 +: 4]]) begin
        win_idx = PRIO_ORDER[k*4 +: 4];
        win_any = 1'b1;
      end
    end
  end

  // Shared-vector flags follow any of their enabled sub-sources becoming set
  assign mf_evt[0] = (tmr0_cmpa_evt_i && timer0_match_int_ctrl_reg[`BIT_SUB_AE])
                   || (tmr0_cmpp_evt_i && timer0_match_int_ctrl_reg[`BIT_SUB_PE]);
  assign mf_evt[1] = (tmr1_cmpa_evt_i && timer1_match_int_ctrl_reg[`BIT_SUB_AE])
                   || (tmr1_cmpp_evt_i && timer1_match_int_ctrl_reg[`BIT_SUB_PE]);
  assign mf_evt[2] = (nvm_write_done_evt_i && eeprom_lowvolt_int_ctrl_reg[`BIT_SUB_AE])
                   || (low_voltage_evt_i && eeprom_lowvolt_int_ctrl_reg[`BIT_SUB_PE]);

  // ---------------------------------------------------------------
  // Service sequencer
  // ---------------------------------------------------------------
  logic take;
  assign take = (state_reg == ST_IDLE) && win_any && core_ready_i
                && primary_int_ctrl_reg[`BIT_GIE]
                && !stack_full_i;
  assign clr_vec = take ? (`NUM_SRC'(1) << win_idx) : '0;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      state_reg <= ST_IDLE;
      irq_take_o <= 1'b0;
      vector_addr_o <= 12'h000;
      push_pc_o <= 12'h000;
      in_service_reg <= 1'b0;
    end else begin
      irq_take_o <= 1'b0;
      unique case (state_reg)
        ST_IDLE: begin
          if (take) begin
            irq_take_o <= 1'b1;
            push_pc_o <= next_pc_i;
            vector_addr_o <= `VEC_BASE + `VEC_STEP * {8'h00, win_idx};
            state_reg <= ST_PUSH;
          end
        end
        ST_PUSH: begin
          in_service_reg <= 1'b1;
          state_reg <= ST_WAIT;
        end
        ST_WAIT: begin
          // Nested entry allowed once software re-enables globally
          state_reg <= ST_IDLE;
        end
      endcase
      if (return_from_irq_instr_i) begin
        in_service_reg <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Register writes and flag setting (set beats clear)
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      primary_int_ctrl_reg <= `RST_BYTE;
    end else begin
      if (wr_hit && avs_address_i == `OFS_PRIMARY) begin
        primary_int_ctrl_reg <= wr_byte & `MASK_PRIMARY;
      end else if (take) begin
        primary_int_ctrl_reg[`BIT_GIE] <= 1'b0;
      end
      if (clr_vec[0]) primary_int_ctrl_reg[`BIT_OVP_F] <= 1'b0;
      if (clr_vec[1]) primary_int_ctrl_reg[`BIT_OCP_F] <= 1'b0;
      if (clr_vec[2]) primary_int_ctrl_reg[`BIT_EXTA_F] <= 1'b0;
      if (overvolt_evt_i) primary_int_ctrl_reg[`BIT_OVP_F] <= 1'b1;
      if (overcurrent_evt_i) primary_int_ctrl_reg[`BIT_OCP_F] <= 1'b1;
      if (pa_edge) primary_int_ctrl_reg[`BIT_EXTA_F] <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      adc_multifunc_int_ctrl_reg <= `RST_BYTE;
    end else begin
      if (wr_hit && avs_address_i == `OFS_ADC_MF) begin
        adc_multifunc_int_ctrl_reg <= wr_byte & `MASK_ADC_MF;
      end
      if (clr_vec[3]) adc_multifunc_int_ctrl_reg[`BIT_ADC_F] <= 1'b0;
      for (int m = 0; m < 3; m++) begin
        if (clr_vec[4+m]) adc_multifunc_int_ctrl_reg[`BIT_MF_F0+m] <= 1'b0;
        if (mf_evt[m]) adc_multifunc_int_ctrl_reg[`BIT_MF_F0+m] <= 1'b1;
      end
      if (adc_done_evt_i) adc_multifunc_int_ctrl_reg[`BIT_ADC_F] <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      ext1_timebase_int_ctrl_reg <= `RST_BYTE;
    end else begin
      if (wr_hit && avs_address_i == `OFS_EXT1_TB) begin
        ext1_timebase_int_ctrl_reg <= wr_byte & `MASK_EXT1_TB;
      end
      if (clr_vec[7]) ext1_timebase_int_ctrl_reg[`BIT_TB_F0] <= 1'b0;
      if (clr_vec[8]) ext1_timebase_int_ctrl_reg[`BIT_TB_F0+1] <= 1'b0;
      if (clr_vec[9]) ext1_timebase_int_ctrl_reg[`BIT_EXTB_F] <= 1'b0;
      if (tick_a_evt_i) ext1_timebase_int_ctrl_reg[`BIT_TB_F0] <= 1'b1;
      if (tick_b_evt_i) ext1_timebase_int_ctrl_reg[`BIT_TB_F0+1] <= 1'b1;
      if (pb_edge) ext1_timebase_int_ctrl_reg[`BIT_EXTB_F] <= 1'b1;
    end
  end

  // Sub-source flags are cleared only by software
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      timer0_match_int_ctrl_reg <= `RST_BYTE;
      timer1_match_int_ctrl_reg <= `RST_BYTE;
      eeprom_lowvolt_int_ctrl_reg <= `RST_BYTE;
      edge_select_reg <= `RST_BYTE;
    end else begin
      if (wr_hit && avs_address_i == `OFS_TMR0) begin
        timer0_match_int_ctrl_reg <= wr_byte & `MASK_SUB;
      end
      if (wr_hit && avs_address_i == `OFS_TMR1) begin
        timer1_match_int_ctrl_reg <= wr_byte & `MASK_SUB;
      end
      if (wr_hit && avs_address_i == `OFS_NVM_LV) begin
        eeprom_lowvolt_int_ctrl_reg <= wr_byte & `MASK_SUB;
      end
      if (wr_hit && avs_address_i == `OFS_EDGE_SEL) begin
        edge_select_reg <= wr_byte & `MASK_EDGE_SEL;
      end
      if (tmr0_cmpa_evt_i) timer0_match_int_ctrl_reg[`BIT_SUB_AF] <= 1'b1;
      if (tmr0_cmpp_evt_i) timer0_match_int_ctrl_reg[`BIT_SUB_PF] <= 1'b1;
      if (tmr1_cmpa_evt_i) timer1_match_int_ctrl_reg[`BIT_SUB_AF] <= 1'b1;
      if (tmr1_cmpp_evt_i) timer1_match_int_ctrl_reg[`BIT_SUB_PF] <= 1'b1;
      if (nvm_write_done_evt_i) eeprom_lowvolt_int_ctrl_reg[`BIT_SUB_AF] <= 1'b1;
      if (low_voltage_evt_i) eeprom_lowvolt_int_ctrl_reg[`BIT_SUB_PF] <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Wake-up and pull-high pass-through
  // ---------------------------------------------------------------
  logic [`NUM_SRC-1:0] flag_prev_reg;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      flag_prev_reg <= '0;
      wake_o <= 1'b0;
      pin_a_pullup_o <= 1'b0;
      pin_b_pullup_o <= 1'b0;
    end else begin
      flag_prev_reg <= src_flag;
      wake_o <= |(src_flag & ~flag_prev_reg);
      pin_a_pullup_o <= pin_a_pullup_i;
      pin_b_pullup_o <= pin_b_pullup_i;
    end
  end

  // ---------------------------------------------------------------
  // Avalon slave: one wait cycle on reads and on writes
  // ---------------------------------------------------------------
  logic rd_pend_reg;
  logic [7:0] rd_mux;

  always_comb begin
    unique case (avs_address_i)
      `OFS_PRIMARY: rd_mux = primary_int_ctrl_reg;
      `OFS_ADC_MF: rd_mux = adc_multifunc_int_ctrl_reg;
      `OFS_EXT1_TB: rd_mux = ext1_timebase_int_ctrl_reg;
      `OFS_TMR0: rd_mux = timer0_match_int_ctrl_reg;
      `OFS_TMR1: rd_mux = timer1_match_int_ctrl_reg;
      `OFS_NVM_LV: rd_mux = eeprom_lowvolt_int_ctrl_reg;
      `OFS_EDGE_SEL: rd_mux = edge_select_reg;
      `OFS_SERVICE: rd_mux = {3'h0, win_any, win_idx};
      `OFS_CORE_STAT: rd_mux = {5'h00, state_reg == ST_IDLE, stack_full_i,
                                in_service_reg};
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rd_pend_reg <= 1'b0;
      avs_readdata_o <= 32'h0000_0000;
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= 1'b1;
      rd_pend_reg <= 1'b0;
      if (avs_read_i && avs_waitrequest_o && !rd_pend_reg) begin
        avs_readdata_o <= {24'h000000, rd_mux};
        rd_pend_reg <= 1'b1;
        avs_waitrequest_o <= 1'b0;
      end else if (avs_write_i && avs_waitrequest_o) begin
        avs_waitrequest_o <= 1'b0;
      end
    end
  end

endmodule

// ===== verilog/vic_consts.svh
/*
  Offsets, field positions, reset values and vectors for the vectored
  interrupt controller. Assumes a 32-bit Avalon-MM byte-addressed slave
  whose byte address is four times the register index.
*/
`ifndef VIC_CONSTS_SVH
`define VIC_CONSTS_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define OFS_PRIMARY     6'h00
`define OFS_ADC_MF      6'h04
`define OFS_EXT1_TB     6'h08
`define OFS_TMR0        6'h0c
`define OFS_TMR1        6'h10
`define OFS_NVM_LV      6'h14
`define OFS_EDGE_SEL    6'h18
`define OFS_SERVICE     6'h1c
`define OFS_CORE_STAT   6'h20

// ---------------------------------------------------------------
// Reset values and read masks
// ---------------------------------------------------------------
`define RST_BYTE        8'h00
`define MASK_PRIMARY    8'h7f
`define MASK_ADC_MF     8'hff
`define MASK_EXT1_TB    8'h77
`define MASK_SUB        8'h33
`define MASK_EDGE_SEL   8'h0f

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define BIT_GIE         0
`define BIT_OVP_E       1
`define BIT_OCP_E       2
`define BIT_EXTA_E      3
`define BIT_OVP_F       4
`define BIT_OCP_F       5
`define BIT_EXTA_F      6
`define BIT_ADC_F       7
`define BIT_MF_F0       4
`define BIT_ADC_E       3
`define BIT_MF_E0       0
`define BIT_EXTB_F      6
`define BIT_TB_F0       4
`define BIT_EXTB_E      2
`define BIT_TB_E0       0
`define BIT_SUB_AF      5
`define BIT_SUB_PF      4
`define BIT_SUB_AE      1
`define BIT_SUB_PE      0

// ---------------------------------------------------------------
// Edge select codes
// ---------------------------------------------------------------
`define EDGE_OFF        2'b00
`define EDGE_RISE       2'b01
`define EDGE_FALL       2'b10
`define EDGE_BOTH       2'b11

// ---------------------------------------------------------------
// Vectors and stack depth
// ---------------------------------------------------------------
`define NUM_SRC         10
`define VEC_BASE        12'h004
`define VEC_STEP        12'h004
`define STACK_DEPTH     4'd8

`endif

// ===== verilog/vic_pkg.sv
/*
  Types for the vectored interrupt controller.
  Assumes vic_consts.svh supplies the numeric constants.
*/
package vic_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_PUSH = 3'b010,
    ST_WAIT = 3'b100
  } svc_state_t;
endpackage
